//--- src/flsu_security.sv
// Flash security and housekeeping: reset load, backdoor key unlock,
// read blanking, command abort on reset and interrupt request.
// Assumes all inputs come from logic on clk; the array read port has one
// cycle of latency and is owned by the loader while the processor is held.
`timescale 1ns/1ps
`default_nettype none
`include "flsu_defs.svh"

// How it works
// - Security derived from stored byte after reset
// - Stored secure byte means secure after reset
// - Key mode writes to key window compare, never launch commands
// - Key access set makes array reads invalid
// - Four matches then key access clear unsecure, field forced to 1:0
// - Bad word, order, count or clear locks
// - Lock keeps chip secured until reset
// - Unlock leaves key and security byte unchanged
// - Key sequence never touches protection register
// - No unlock from debug in special single chip
// - Processor held while configuration loads
// - Reset aborts any running program or erase
// - Interrupt from enabled flags, globally maskable
// - Complete flag sets unless command buffered
module flsu_security (
  input wire logic clk,
  input wire logic rst,
  // Array read port, shared between loader and processor reads
  output logic arr_rd_en_q,
  output logic [15:0] arr_rd_addr_q,
  input wire logic [15:0] arr_rd_data,
  output logic cpu_hold_q,
  // Processor write and read on the flash address space
  input wire logic cpu_wr,
  input wire logic [15:0] cpu_addr,
  input wire logic [15:0] cpu_wdata,
  input wire logic cpu_rd,
  output logic [15:0] cpu_rd_data_q,
  output logic array_wr_pass_q,
  // Configuration and mode
  input wire logic key_access_bit,
  input wire logic debug_halt_mode,
  input wire logic special_single_chip,
  // Security and protection results
  output logic [7:0] security_reg_q,
  output logic [1:0] security_state_field_q,
  output logic [1:0] key_enable_field_q,
  output logic [7:0] protection_reg_q,
  output logic secured_q,
  output logic key_locked_q,
  // Command engine housekeeping
  output logic cmd_abort_q,
  input wire logic cmd_launch,
  input wire logic cmd_done,
  input wire logic cmd_buffered,
  input wire logic buffer_empty_flag,
  input wire logic buffer_empty_irq_en,
  input wire logic command_complete_irq_en,
  input wire logic cpu_irq_mask,
  output logic command_complete_flag_q,
  output logic irq_q
);
  logic [15:0] key_word [4];
  logic [7:0] prot_byte, sec_byte;
  logic load_done;
  logic [15:0] rd_data_d;
  logic wr_pass_d;
  logic [7:0] sec_reg_d;
  logic [7:0] prot_reg_d;
  logic secured_d, locked_d, hold_d, abort_d;
  logic cc_flag_d, irq_d;
  flsu_pkg::flsu_sec_state_t st_q, st_d;
  logic [1:0] idx_q, idx_d;
  logic key_mode, key_hit, word_ok;

  flsu_cfg_loader u_loader (
    .clk(clk),
    .rst(rst),
    .arr_rd_en_q(arr_rd_en_q),
    .arr_rd_addr_q(arr_rd_addr_q),
    .arr_rd_data(arr_rd_data),
    .key_word(key_word),
    .prot_byte_q(prot_byte),
    .sec_byte_q(sec_byte),
    .done_q(load_done)
  );

  // Address falls in the backdoor key window
  function automatic logic in_key_window(input logic [15:0] a);
    in_key_window = (a >= `FLSU_KEY_BASE) && (a <= `FLSU_KEY_LAST);
  endfunction

  // Security field encodes the unsecure state
  function automatic logic is_unsecure(input logic [7:0] b);
    is_unsecure = (b[`FLSU_SEC_HI:`FLSU_SEC_LO] == `FLSU_SEC_UNSECURE);
  endfunction

  // Key compare mode uses the loaded enable field, not the forced copy
  assign key_mode = (sec_byte[`FLSU_KEY_EN_HI:`FLSU_KEY_EN_LO] == `FLSU_KEY_EN_ON)
                    && key_access_bit;
  assign key_hit = cpu_wr && key_mode && in_key_window(cpu_addr);
  // A word is good only at the expected aligned slot, legal and matching
  assign word_ok = !cpu_addr[0] && (cpu_addr[2:1] == idx_q)
                   && (cpu_wdata != `FLSU_KEY_BAD_LO) && (cpu_wdata != `FLSU_KEY_BAD_HI)
                   && (cpu_wdata == key_word[idx_q]);

  // Backdoor key state machine
  always_comb begin
    st_d = st_q;
    idx_d = idx_q;
    case (st_q)
      flsu_pkg::SEC_LOAD: begin
        if (load_done) begin
          st_d = flsu_pkg::SEC_IDLE;
        end
      end
      flsu_pkg::SEC_IDLE, flsu_pkg::SEC_OPEN: begin
        idx_d = 2'h0;
        if (key_hit) begin
          // A wrong first word locks straight away
          st_d = word_ok ? flsu_pkg::SEC_ARMED : flsu_pkg::SEC_LOCK;
          idx_d = 2'h1;
        end
      end
      flsu_pkg::SEC_ARMED: begin
        if (!key_access_bit) begin
          st_d = flsu_pkg::SEC_LOCK;
        end else if (key_hit) begin
          if (!word_ok) begin
            st_d = flsu_pkg::SEC_LOCK;
          end else if (idx_q == 2'h3) begin
            st_d = flsu_pkg::SEC_FULL;
          end else begin
            idx_d = idx_q + 2'h1;
          end
        end
      end
      flsu_pkg::SEC_FULL: begin
        if (key_hit) begin
          st_d = flsu_pkg::SEC_LOCK;
        end else if (!key_access_bit) begin
          // Decision waits for the clear; debug in single chip is refused
          st_d = (debug_halt_mode && special_single_chip) ?
                 flsu_pkg::SEC_LOCK : flsu_pkg::SEC_OPEN;
        end
      end
      flsu_pkg::SEC_LOCK: begin
        st_d = flsu_pkg::SEC_LOCK;
      end
      default: begin
        st_d = flsu_pkg::SEC_LOCK;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= flsu_pkg::SEC_LOAD;
      idx_q <= 2'h0;
    end else begin
      st_q <= st_d;
      idx_q <= idx_d;
    end
  end

  // Security, protection and hold outputs
  always_comb begin
    // Stored byte governs until an unlock; the stored byte itself never changes
    sec_reg_d = sec_byte;
    if (st_d == flsu_pkg::SEC_OPEN) begin
      sec_reg_d[`FLSU_SEC_HI:`FLSU_SEC_LO] = `FLSU_SEC_UNSECURE;
    end
    // Protection comes only from the array, never from the key machine
    prot_reg_d = prot_byte;
    secured_d = !is_unsecure(sec_reg_d) || (st_d == flsu_pkg::SEC_LOAD);
    locked_d = (st_d == flsu_pkg::SEC_LOCK);
    hold_d = !load_done;
    // Command engine stays aborted through reset and the load
    abort_d = !load_done;
  end

  // Read blanking, write routing, completion flag and interrupt
  always_comb begin
    rd_data_d = cpu_rd_data_q;
    if (cpu_rd) begin
      rd_data_d = key_access_bit ? `FLSU_READ_INVALID : arr_rd_data;
    end
    // Array writes go to the command logic once the load is done, unless they hit the key window in key compare mode
    wr_pass_d = cpu_wr && !key_hit && load_done;
    cc_flag_d = command_complete_flag_q;
    if (cmd_launch) begin
      cc_flag_d = 1'b0;
    end
    // Setting wins over a launch in the same cycle
    if (cmd_done && !cmd_buffered) begin
      cc_flag_d = 1'b1;
    end
    irq_d = ((buffer_empty_flag && buffer_empty_irq_en)
             || (command_complete_flag_q && command_complete_irq_en))
            && !cpu_irq_mask;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      security_reg_q <= `FLSU_SEC_RST;
      security_state_field_q <= 2'h3;
      key_enable_field_q <= 2'h3;
      protection_reg_q <= `FLSU_PROT_RST;
      secured_q <= 1'b1;
      key_locked_q <= 1'b0;
      cpu_hold_q <= 1'b1;
      cmd_abort_q <= 1'b1;
      cpu_rd_data_q <= `FLSU_READ_INVALID;
      array_wr_pass_q <= 1'b0;
      command_complete_flag_q <= 1'b1;
      irq_q <= 1'b0;
    end else begin
      security_reg_q <= sec_reg_d;
      security_state_field_q <= sec_reg_d[`FLSU_SEC_HI:`FLSU_SEC_LO];
      key_enable_field_q <= sec_reg_d[`FLSU_KEY_EN_HI:`FLSU_KEY_EN_LO];
      protection_reg_q <= prot_reg_d;
      secured_q <= secured_d;
      key_locked_q <= locked_d;
      cpu_hold_q <= hold_d;
      cmd_abort_q <= abort_d;
      cpu_rd_data_q <= rd_data_d;
      array_wr_pass_q <= wr_pass_d;
      command_complete_flag_q <= cc_flag_d;
      irq_q <= irq_d;
    end
  end
endmodule // flsu_security

`default_nettype wire

//--- common/flsu_defs.svh
// Constants of the flash security and housekeeping block.
// Included by the design files; holds defines only.
`ifndef FLSU_DEFS_SVH
`define FLSU_DEFS_SVH

// Configuration field locations (byte addresses in the flash map)
`define FLSU_KEY_BASE 16'hff00
`define FLSU_KEY_LAST 16'hff07
`define FLSU_PROT_WORD 16'hff0c
`define FLSU_SEC_WORD 16'hff0e
`define FLSU_SEC_BYTE 16'hff0f

// Layout of the security/options byte
`define FLSU_KEY_EN_HI 7
`define FLSU_KEY_EN_LO 6
`define FLSU_SEC_HI 1
`define FLSU_SEC_LO 0

// Encodings
`define FLSU_KEY_EN_ON 2'h2
`define FLSU_SEC_UNSECURE 2'h2
`define FLSU_KEY_BAD_LO 16'h0000
`define FLSU_KEY_BAD_HI 16'hffff
`define FLSU_READ_INVALID 16'hffff

// Reset values
`define FLSU_SEC_RST 8'hff
`define FLSU_PROT_RST 8'hff
`define FLSU_KEY_RST 16'hffff

// Loader sequence: four key words, protection word, security word
`define FLSU_LOAD_STEPS 3'h6

`endif

//--- common/flsu_pkg.sv
// Types shared by the flash security block.
// Assumes flsu_defs.svh is on the include path.
`default_nettype none
package flsu_pkg;
  typedef enum logic [5:0] {
    SEC_LOAD  = 6'h01,
    SEC_IDLE  = 6'h02,
    SEC_ARMED = 6'h04,
    SEC_FULL  = 6'h08,
    SEC_OPEN  = 6'h10,
    SEC_LOCK  = 6'h20
  } flsu_sec_state_t;
endpackage

`default_nettype wire

//--- src/flsu_cfg_loader.sv
// Reset-time loader: reads the configuration field out of the array.
// Assumes an array read port returning data one clock after the request.
`timescale 1ns/1ps
`default_nettype none
`include "flsu_defs.svh"

module flsu_cfg_loader (
  input wire logic clk,
  input wire logic rst,
  output logic arr_rd_en_q,
  output logic [15:0] arr_rd_addr_q,
  input wire logic [15:0] arr_rd_data,
  output logic [15:0] key_word [4],
  output logic [7:0] prot_byte_q,
  output logic [7:0] sec_byte_q,
  output logic done_q
);
  logic [2:0] step_q, step_d;
  logic [15:0] key_q [4];
  logic [15:0] key_d [4];
  logic [7:0] prot_d, sec_d;
  logic rd_en_d, done_d;
  logic [15:0] rd_addr_d;

  // Step number to word address of the configuration field
  function automatic logic [15:0] step_addr(input logic [2:0] s);
    case (s)
      3'h4: step_addr = `FLSU_PROT_WORD;
      3'h5: step_addr = `FLSU_SEC_WORD;
      default: step_addr = `FLSU_KEY_BASE + {13'h0000, s[1:0], 1'b0};
    endcase
  endfunction

  always_comb begin
    step_d = step_q;
    key_d = key_q;
    prot_d = prot_byte_q;
    sec_d = sec_byte_q;
    rd_en_d = 1'b0;
    rd_addr_d = arr_rd_addr_q;
    done_d = done_q;
    if (!done_q) begin
      if (step_q < `FLSU_LOAD_STEPS) begin
        rd_en_d = 1'b1;
        rd_addr_d = step_addr(step_q);
      end
      if (arr_rd_en_q) begin
        // Data for the previous step arrives now; the odd bytes are the low lanes
        case (step_q - 3'h1)
          3'h4: prot_d = arr_rd_data[7:0];
          3'h5: sec_d = arr_rd_data[7:0];
          default: key_d[2'(step_q - 3'h1)] = arr_rd_data;
        endcase
      end
      if (step_q == `FLSU_LOAD_STEPS) begin
        done_d = 1'b1;
      end else begin
        step_d = step_q + 3'h1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      step_q <= 3'h0;
      for (int i = 0; i < 4; i++) key_q[i] <= `FLSU_KEY_RST;
      prot_byte_q <= `FLSU_PROT_RST;
      sec_byte_q <= `FLSU_SEC_RST;
      arr_rd_en_q <= 1'b0;
      arr_rd_addr_q <= 16'h0000;
      done_q <= 1'b0;
    end else begin
      step_q <= step_d;
      key_q <= key_d;
      prot_byte_q <= prot_d;
      sec_byte_q <= sec_d;
      arr_rd_en_q <= rd_en_d;
      arr_rd_addr_q <= rd_addr_d;
      done_q <= done_d;
    end
  end

  assign key_word = key_q;
endmodule // flsu_cfg_loader

`default_nettype wire

//--- tb/flsu_security_properties.sv
// Port checker for the flash security block, bound to its top module.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module flsu_security_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic cpu_wr,
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_rd,
  input wire logic key_access_bit,
  input wire logic debug_halt_mode,
  input wire logic special_single_chip,
  input wire logic cmd_done,
  input wire logic cmd_buffered,
  input wire logic buffer_empty_flag,
  input wire logic buffer_empty_irq_en,
  input wire logic command_complete_irq_en,
  input wire logic cpu_irq_mask,
  input wire logic arr_rd_en_q,
  input wire logic cpu_hold_q,
  input wire logic [15:0] cpu_rd_data_q,
  input wire logic array_wr_pass_q,
  input wire logic [7:0] security_reg_q,
  input wire logic [1:0] security_state_field_q,
  input wire logic [1:0] key_enable_field_q,
  input wire logic [7:0] protection_reg_q,
  input wire logic secured_q,
  input wire logic key_locked_q,
  input wire logic cmd_abort_q,
  input wire logic command_complete_flag_q,
  input wire logic irq_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  key_no_pass_a: assert property (cpu_wr && key_access_bit &&
    key_enable_field_q == 2'h2 && cpu_addr[15:3] == 13'h1fe0 |=> !array_wr_pass_q)
    else $error("key write passed to array");
  read_blank_a: assert property (cpu_rd && key_access_bit |=>
    cpu_rd_data_q == 16'hffff) else $error("array read not blanked");
  unsec_field_a: assert property ($fell(secured_q) |->
    security_state_field_q == 2'h2) else $error("unsecure field wrong");
  unlock_clear_a: assert property ($fell(secured_q) && !$past(cpu_hold_q) |->
    !$past(key_access_bit)) else $error("unlock before access cleared");
  lock_hold_a: assert property (key_locked_q |=>
    key_locked_q && $stable(secured_q)) else $error("lock released");
  prot_fixed_a: assert property (!cpu_hold_q |=>
    $stable(protection_reg_q)) else $error("protection changed");
  sec_byte_a: assert property (!cpu_hold_q |=>
    security_reg_q[7:2] == $past(security_reg_q[7:2])) else $error("security byte changed");
  debug_refuse_a: assert property (debug_halt_mode && special_single_chip &&
    secured_q && !cpu_hold_q |=> secured_q) else $error("unsecured from debug");
  load_hold_a: assert property (arr_rd_en_q |->
    cpu_hold_q && cmd_abort_q) else $error("processor free during load");
  flag_set_a: assert property (cmd_done && !cmd_buffered |=>
    command_complete_flag_q) else $error("complete flag not set");
  irq_req_a: assert property (!$past(rst) |-> irq_q == $past(
    ((buffer_empty_flag && buffer_empty_irq_en) ||
    (command_complete_flag_q && command_complete_irq_en)) && !cpu_irq_mask))
    else $error("interrupt request wrong");
  cover property ($fell(secured_q));
  cover property ($rose(key_locked_q));
  cover property ($rose(irq_q));
endmodule // flsu_security_chk
bind flsu_security flsu_security_chk u_chk (.*);
`default_nettype wire

//--- tb/flsu_flash_model.sv
// Array model: key words and configuration bytes, one cycle read latency.
// Assumes reads come from the loader or from processor reads only.
`timescale 1ns/1ps
`default_nettype none
module flsu_flash_model #(
  parameter logic [15:0] K0 = 16'h1a2b,
  parameter logic [15:0] K1 = 16'h3c4d,
  parameter logic [15:0] K2 = 16'h5e6f,
  parameter logic [15:0] K3 = 16'h7a8b
) (
  input wire logic clk,
  input wire logic arr_rd_en_q,
  input wire logic [15:0] arr_rd_addr_q,
  input wire logic cpu_rd,
  input wire logic [15:0] cpu_addr,
  input wire logic [7:0] sec_byte,
  output logic [15:0] arr_rd_data
);
  logic [15:0] a;
  assign a = arr_rd_en_q ? arr_rd_addr_q : cpu_addr;
  // Data stands in the cycle the registered request is on the port, so the
  // design takes it at the next edge; idle cycles show a garbage pattern
  always_comb begin
    arr_rd_data = 16'h5aa5;
    if (arr_rd_en_q || cpu_rd) begin
      case (a)
        16'hff00: arr_rd_data = K0;
        16'hff02: arr_rd_data = K1;
        16'hff04: arr_rd_data = K2;
        16'hff06: arr_rd_data = K3;
        16'hff0c: arr_rd_data = 16'hffa5;
        16'hff0e: arr_rd_data = {8'hff, sec_byte};
        default: arr_rd_data = ~a;
      endcase
    end
  end
endmodule // flsu_flash_model
`default_nettype wire

//--- tb/test_flash_security_unlock_ctrl.sv
// Self-checking bench for the flash security block.
// Assumes the array model and the bound checker are compiled with it.
`timescale 1ns/1ps
`default_nettype none
module test_flash_security_unlock_ctrl;
  logic clk = 0, rst = 1, cpu_wr = 0, cpu_rd = 0, key_access_bit = 0, debug_halt_mode = 0;
  logic special_single_chip = 0, cmd_launch = 0, cmd_done = 0, cmd_buffered = 0;
  logic buffer_empty_flag = 0, buffer_empty_irq_en = 0, command_complete_irq_en = 0;
  logic cpu_irq_mask = 0, arr_rd_en_q, cpu_hold_q, array_wr_pass_q, secured_q, key_locked_q;
  logic cmd_abort_q, command_complete_flag_q, irq_q, e;
  logic [15:0] cpu_addr = 0, cpu_wdata = 0, arr_rd_data, arr_rd_addr_q, cpu_rd_data_q;
  logic [7:0] sec_byte = 8'hbd, security_reg_q, protection_reg_q;
  logic [1:0] security_state_field_q, key_enable_field_q;
  int fail_count = 0, compares = 0;
  integer seed = 32'ha8290df2;
  flsu_security DUT (.*);
  flsu_flash_model u_arr (.*);
  always #5 clk = ~clk;
  function automatic logic [15:0] kw(input int i);
    return i == 0 ? 16'h1a2b : i == 1 ? 16'h3c4d : i == 2 ? 16'h5e6f : 16'h7a8b;
  endfunction
  task chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task results;
    if (fail_count == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task do_reset;
    rst <= 1;
    repeat (4) @(posedge clk);
    chk(cmd_abort_q, 1);
    rst <= 0;
    repeat (4) @(posedge clk);
    chk(cpu_hold_q, 1);
    repeat (8) @(posedge clk);
  endtask
  task wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    cpu_wr <= 1;
    cpu_addr <= a;
    cpu_wdata <= d;
    @(posedge clk);
    cpu_wr <= 0;
  endtask
  task rd(input logic [15:0] a);
    @(posedge clk);
    cpu_rd <= 1;
    cpu_addr <= a;
    @(posedge clk);
    cpu_rd <= 0;
    @(posedge clk);
    #1;
  endtask
  // Fault codes 0..6 break the sequence one way each; 7 is a clean run
  task key_seq(input int f);
    logic [15:0] w;
    @(posedge clk);
    key_access_bit <= 1;
    debug_halt_mode <= (f == 6);
    special_single_chip <= (f == 6);
    for (int i = 0; i < 4; i++) begin
      w = kw(i);
      if (f == 0 && i == 2) w = w ^ {8'h00, 8'($random(seed)) | 8'h01};
      if (f == 3 && i == 1) w = 16'h0000;
      if (f == 4 && i == 3) w = 16'hffff;
      if (f == 5 && i == 2) key_access_bit <= 0;
      wr((f == 1 && i == 0) ? 16'hff02 : 16'hff00 + 16'(2 * i), w);
    end
    if (f == 2) wr(16'hff00, kw(0));
    if (f != 5) begin
      rd(16'h4000);
      chk(cpu_rd_data_q, 16'hffff);
    end
    chk(secured_q, 1);
    @(posedge clk);
    key_access_bit <= 0;
    repeat (3) @(posedge clk);
    #1;
    debug_halt_mode <= 0;
    special_single_chip <= 0;
  endtask
  initial begin
    do_reset;
    chk(protection_reg_q, 8'ha5);
    chk(security_reg_q, sec_byte);
    chk(secured_q, 1);
    chk(key_enable_field_q, 2'h2);
    chk(security_state_field_q, 2'h1);
    wr(16'h4000, 16'h1234);
    #1;
    chk(array_wr_pass_q, 1);
    rd(16'h4000);
    chk(cpu_rd_data_q, 16'hbfff);
    for (int f = 0; f < 7; f++) begin
      do_reset;
      key_seq(f);
      chk(key_locked_q, 1);
      key_seq(7);
      chk(secured_q, 1);
    end
    do_reset;
    key_seq(7);
    chk(secured_q, 0);
    chk(security_state_field_q, 2'h2);
    chk(security_reg_q[7:2], sec_byte[7:2]);
    chk(protection_reg_q, 8'ha5);
    do_reset;
    chk(secured_q, 1);
    sec_byte <= 8'hbe;
    do_reset;
    chk(secured_q, 0);
    @(posedge clk);
    cmd_done <= 1;
    cmd_buffered <= 1;
    cmd_launch <= 1;
    @(posedge clk);
    cmd_done <= 0;
    cmd_launch <= 0;
    #1;
    chk(command_complete_flag_q, 0);
    @(posedge clk);
    #1;
    repeat (300) begin
      e = ((buffer_empty_flag && buffer_empty_irq_en) ||
           (command_complete_flag_q && command_complete_irq_en)) && !cpu_irq_mask;
      @(posedge clk);
      {buffer_empty_flag, buffer_empty_irq_en, command_complete_irq_en, cpu_irq_mask,
       cmd_done, cmd_launch, cmd_buffered} <= 7'($random(seed));
      #1;
      chk(irq_q, e);
    end
    results;
  end
  initial begin
    #100000;
    fail_count++;
    results;
  end
endmodule // test_flash_security_unlock_ctrl
`default_nettype wire
